// ===== page_jump_and_logic_and_exec.sv
`timescale 1ns/10ps

// Summary of operation
// RL1 - The jump advances the program counter by two and then replaces bits 10..0 with the page target, keeping bits above.
// RL2 - Page target bits 10..8 come from opcode bits 7..5 and bits 7..0 from the second instruction byte.
// RL3 - The jump is recognised by low opcode bits 00001, is two bytes long and takes two machine cycles.
// RL4 - The byte AND writes the bitwise AND of its operands to the destination and touches no status flag.
// RL5 - Six forms exist: accumulator with register, direct, indirect or immediate, and direct with accumulator or immediate.
// RL6 - When a direct destination is modified, its old value is read from the output latch, not from the pins.
// RL7 - Opcode 01011rrr ANDs a working register into the accumulator, one byte, one machine cycle.
// RL8 - Opcode 01010101 ANDs a direct byte into the accumulator, two bytes, one machine cycle.
// RL9 - Opcode 0101011i ANDs the byte addressed by a pointer register into the accumulator, one byte, one cycle.
// RL10 - Opcode 01010100 ANDs the second-byte constant into the accumulator, two bytes, one machine cycle.
// RL11 - A direct destination may be any internal RAM byte or special-function register, masked by immediate or accumulator.
// RL12 - The rrr field picks one of eight registers of the active bank and the i bit picks register 0 or 1 as pointer.
module page_jump_and_logic_and_exec
  import page_jump_and_pkg::*;
#(
  parameter int PC_W = 16
) (
  // Clock and reset
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  // Instruction from fetch
  input  wire logic            i_instr_valid,
  input  wire logic [7:0]      i_opcode,
  input  wire logic [7:0]      i_byte2,
  input  wire logic [7:0]      i_byte3,
  input  wire logic [PC_W-1:0] i_pc,
  // Core state
  input  wire logic [7:0]      i_acc,
  input  wire logic [1:0]      i_bank,
  // Data memory read port
  input  wire logic [7:0]      i_mem_rdata,
  // Handshake to fetch
  output logic                 o_ready,
  output logic                 o_done,
  output logic [1:0]           o_bytes,
  output logic [1:0]           o_cycles,
  output logic                 o_unsupported,
  // Data memory access
  output logic                 o_mem_rd,
  output logic                 o_mem_wr,
  output logic [7:0]           o_mem_addr,
  output logic                 o_mem_sfr,
  output logic                 o_mem_latch,
  output logic [7:0]           o_mem_wdata,
  // Accumulator write
  output logic                 o_acc_wr,
  output logic [7:0]           o_acc_data,
  // Program counter load
  output logic                 o_pc_load,
  output logic [PC_W-1:0]      o_pc_target
);

  // Opcode classification for every form this block executes
  function automatic kind_t decode_kind(input logic [7:0] op);
    kind_t k;
    k = K_NONE;
    if ((op & JMP_MASK) == JMP_CODE)          k = K_JMP;      // see RL3
    else if ((op & REG_MASK) == AND_REG_CODE) k = K_ACC_REG;  // see RL7
    else if ((op & IND_MASK) == AND_IND_CODE) k = K_ACC_IND;  // see RL9
    else if (op == AND_DIR_CODE)              k = K_ACC_DIR;  // see RL8
    else if (op == AND_IMM_CODE)              k = K_ACC_IMM;  // see RL10
    else if (op == DIR_ACC_CODE)              k = K_DIR_ACC;  // see RL5
    else if (op == DIR_IMM_CODE)              k = K_DIR_IMM;  // see RL5
    return k;
  endfunction : decode_kind

  state_t          state_q;
  state_t          state_d;
  kind_t           kind_q;
  logic [7:0]      opnd_q;
  logic [7:0]      imm_q;
  logic            ready_q;
  logic            done_q;
  logic [1:0]      bytes_q;
  logic [1:0]      cycles_q;
  logic            unsup_q;
  logic            mem_rd_q;
  logic            mem_wr_q;
  logic [7:0]      mem_addr_q;
  logic            mem_sfr_q;
  logic            mem_latch_q;
  logic [7:0]      mem_wdata_q;
  logic            acc_wr_q;
  logic [7:0]      acc_data_q;
  logic            pc_load_q;
  logic [PC_W-1:0] pc_target_q;

  // Decode of the offered instruction
  wire kind_t           kind_w    = decode_kind(i_opcode);
  wire logic            accept    = i_instr_valid && (state_q == ST_IDLE);
  wire logic            take_jmp  = accept && (kind_w == K_JMP);
  wire logic            take_and  = accept && (kind_w != K_JMP) && (kind_w != K_NONE);
  wire logic            dest_dir  = (kind_w == K_DIR_ACC) || (kind_w == K_DIR_IMM);

  // Jump target: counter stepped past both bytes, then the low page replaced
  wire logic [PC_W-1:0] pc_step   = i_pc + PC_W'(JMP_PC_STEP);                    // see RL1
  wire logic [PC_W-1:0] jmp_tgt   = {pc_step[PC_W-1:PAGE_W], i_opcode[7:5], i_byte2}; // see RL1 see RL2

  // Register-file addresses inside the active bank
  wire logic [7:0]      reg_addr  = {3'h0, i_bank, i_opcode[2:0]};               // see RL12
  wire logic [7:0]      ptr_addr  = {3'h0, i_bank, 2'h0, i_opcode[0]};           // see RL12
  wire logic [7:0]      first_adr = (kind_w == K_ACC_REG) ? reg_addr :
                                    (kind_w == K_ACC_IND) ? ptr_addr : i_byte2;

  // Lengths reported back to fetch
  wire logic [1:0]      len_w     = (kind_w == K_DIR_IMM) ? LEN_3 :
                                    ((kind_w == K_ACC_REG) || (kind_w == K_ACC_IND)) ? LEN_1 : LEN_2;
  wire logic [1:0]      cyc_w     = ((kind_w == K_JMP) || (kind_w == K_DIR_IMM)) ? CYC_2 : CYC_1;

  // Mask operand: a constant for the direct-immediate form, else the live accumulator
  wire logic [7:0]      mask_w    = (kind_q == K_DIR_IMM) ? imm_q : i_acc;
  wire logic [7:0]      result_w  = opnd_q & mask_w;                              // see RL4
  wire logic            wb_dir    = (kind_q == K_DIR_ACC) || (kind_q == K_DIR_IMM);

  // Sequencer: indirect form visits the pointer read first, immediate skips reads
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (take_and) begin
          if (kind_w == K_ACC_IMM)      state_d = ST_WB;
          else if (kind_w == K_ACC_IND) state_d = ST_RD_PTR;                     // see RL9
          else                          state_d = ST_RD_SRC;
        end
      end
      ST_RD_PTR: state_d = ST_RD_SRC;
      ST_RD_SRC: state_d = ST_WB;
      ST_WB:     state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == ST_IDLE);
    end
  end

  // Captured instruction form and operands
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kind_q <= K_NONE;
      imm_q  <= BYTE_RST;
      opnd_q <= BYTE_RST;
    end else begin
      if (take_and) begin
        kind_q <= kind_w;
        imm_q  <= i_byte3;
      end
      if (take_and && kind_w == K_ACC_IMM)
        opnd_q <= i_byte2;                                                        // see RL10
      else if (state_q == ST_RD_SRC)
        opnd_q <= i_mem_rdata;
    end
  end

  // Memory reads; read data is valid while the read strobe is high.
  // The latch flag makes a port register return its output latch.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_rd_q    <= 1'b0;
      mem_addr_q  <= BYTE_RST;
      mem_sfr_q   <= 1'b0;
      mem_latch_q <= 1'b0;
    end else if (take_and && kind_w != K_ACC_IMM) begin
      mem_rd_q    <= 1'b1;
      mem_addr_q  <= first_adr;
      mem_sfr_q   <= !(kind_w == K_ACC_REG || kind_w == K_ACC_IND) && (i_byte2 >= SFR_BASE); // see RL11
      mem_latch_q <= dest_dir;                                                    // see RL6
    end else if (state_q == ST_RD_PTR) begin
      mem_addr_q  <= i_mem_rdata;                                                 // see RL9
      mem_sfr_q   <= 1'b0;
    end else if (state_q == ST_RD_SRC) begin
      mem_rd_q    <= 1'b0;
    end else if (state_q == ST_WB) begin
      mem_latch_q <= 1'b0;
    end
  end

  // Writeback pulses; status flags have no path out of this block
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_wr_q    <= 1'b0;
      acc_data_q  <= BYTE_RST;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= BYTE_RST;
    end else begin
      acc_wr_q <= (state_q == ST_WB) && !wb_dir;                                 // see RL4
      mem_wr_q <= (state_q == ST_WB) && wb_dir;                                  // see RL11
      if (state_q == ST_WB) begin
        acc_data_q  <= result_w;
        mem_wdata_q <= result_w;
      end
    end
  end

  // Completion report and jump load
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_q      <= 1'b0;
      bytes_q     <= 2'h0;
      cycles_q    <= 2'h0;
      unsup_q     <= 1'b0;
      pc_load_q   <= 1'b0;
      pc_target_q <= '0;
    end else begin
      done_q    <= take_jmp || (state_q == ST_WB);
      unsup_q   <= accept && (kind_w == K_NONE);
      pc_load_q <= take_jmp;                                                      // see RL1
      if (take_jmp) begin
        pc_target_q <= jmp_tgt;
        bytes_q     <= LEN_2;                                                     // see RL3
        cycles_q    <= CYC_2;                                                     // see RL3
      end else if (take_and) begin
        bytes_q     <= len_w;                                                     // see RL7 see RL8
        cycles_q    <= cyc_w;
      end
    end
  end

  // Every output straight from a flip-flop
  assign o_ready       = ready_q;
  assign o_done        = done_q;
  assign o_bytes       = bytes_q;
  assign o_cycles      = cycles_q;
  assign o_unsupported = unsup_q;
  assign o_mem_rd      = mem_rd_q;
  assign o_mem_wr      = mem_wr_q;
  assign o_mem_addr    = mem_addr_q;
  assign o_mem_sfr     = mem_sfr_q;
  assign o_mem_latch   = mem_latch_q;
  assign o_mem_wdata   = mem_wdata_q;
  assign o_acc_wr      = acc_wr_q;
  assign o_acc_data    = acc_data_q;
  assign o_pc_load     = pc_load_q;
  assign o_pc_target   = pc_target_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Step sequences of the multi-cycle forms
  sequence s_reg_path;
    o_mem_rd ##1 (!o_mem_rd && !o_acc_wr) ##1 (o_acc_wr && o_done);
  endsequence
  sequence s_ind_path;
    o_mem_rd ##1 o_mem_rd ##1 !o_mem_rd ##1 (o_acc_wr && o_done && o_bytes == LEN_1);
  endsequence

  jump_target_a: assert property (take_jmp |=> o_pc_load && o_pc_target == $past(jmp_tgt)) // see RL1
    else $error("jump target not loaded");
  jump_page_a: assert property (take_jmp |=> // see RL2
    o_pc_target[10:8] == $past(i_opcode[7:5]) && o_pc_target[7:0] == $past(i_byte2))
    else $error("page target bits misplaced");
  jump_length_a: assert property (o_pc_load |-> o_done && o_bytes == 2'h2 && o_cycles == 2'h2) // see RL3
    else $error("jump length report wrong");
  reg_path_a: assert property (take_and && kind_w == K_ACC_REG |=> s_reg_path) // see RL7
    else $error("register form sequence wrong");
  reg_bank_a: assert property (take_and && kind_w == K_ACC_REG |=> // see RL12
    o_mem_addr == {3'h0, $past(i_bank), $past(i_opcode[2:0])})
    else $error("working register address wrong");
  ind_path_a: assert property (take_and && kind_w == K_ACC_IND |=> s_ind_path) // see RL9
    else $error("indirect form sequence wrong");
  imm_timing_a: assert property (take_and && kind_w == K_ACC_IMM |=> // see RL10
    !o_mem_rd ##1 (o_acc_wr && o_cycles == 2'h1 && o_bytes == 2'h2))
    else $error("immediate form timing wrong");
  // Source is the read data two cycles back when a read ran there, else the immediate byte
  and_result_a: assert property (o_acc_wr |-> !o_mem_wr && // see RL4
    o_acc_data == ($past(i_acc) & ($past(o_mem_rd, 2) ? $past(i_mem_rdata, 2) : $past(i_byte2, 2))))
    else $error("accumulator result wrong");
  latch_read_a: assert property (take_and && dest_dir |=> // see RL6
    o_mem_rd && o_mem_latch && o_mem_addr == $past(i_byte2))
    else $error("direct destination not read from latch");
  dir_write_a: assert property (o_mem_wr |-> !o_acc_wr && // see RL11
    o_mem_addr == $past(o_mem_addr, 2) && $past(o_mem_latch, 2))
    else $error("direct write misdirected");

  // Direct-destination forms: latched read, one idle cycle, then write back to the same byte
  sequence s_dir_path;
    (o_mem_rd && o_mem_latch) ##1 (!o_mem_rd && !o_mem_wr) ##1 (o_mem_wr && o_done && !o_acc_wr);
  endsequence

  dir_path_a: assert property (take_and && dest_dir |=> s_dir_path) // see RL5
    else $error("direct form sequence wrong");
  dir_space_a: assert property (take_and && dest_dir |=> o_mem_sfr == ($past(i_byte2) >= SFR_BASE)) // see RL11
    else $error("direct space flag wrong");
  dir_imm_a: assert property (take_and && kind_w == K_DIR_IMM |=> ##2 // see RL11
    o_bytes == LEN_3 && o_cycles == CYC_2 && o_mem_wdata == ($past(i_byte3, 3) & $past(i_mem_rdata, 2)))
    else $error("direct immediate mask wrong");
  dir_acc_a: assert property (take_and && kind_w == K_DIR_ACC |=> ##2 // see RL5
    o_bytes == LEN_2 && o_cycles == CYC_1 && o_mem_wdata == ($past(i_acc) & $past(i_mem_rdata, 2)))
    else $error("direct accumulator mask wrong");
  acc_dir_a: assert property (take_and && kind_w == K_ACC_DIR |=> // see RL8
    o_mem_rd && !o_mem_latch && o_mem_addr == $past(i_byte2) ##2 (o_acc_wr && o_bytes == LEN_2 && o_cycles == CYC_1))
    else $error("direct source form wrong");
  ind_ptr_a: assert property (take_and && kind_w == K_ACC_IND |=> // see RL12
    o_mem_addr == {3'h0, $past(i_bank), 2'h0, $past(i_opcode[0])} ##1 o_mem_addr == $past(i_mem_rdata))
    else $error("pointer register path wrong");
  foreign_op_a: assert property (accept && kind_w == K_NONE |=> // see RL5
    o_unsupported && !o_done && !o_pc_load && !o_acc_wr && !o_mem_rd)
    else $error("foreign opcode acted on");
  and_busy_a: assert property (take_and |=> !o_ready) // see RL5
    else $error("busy instruction left ready high");

endmodule : page_jump_and_logic_and_exec

// ===== page_jump_and_pkg.sv
package page_jump_and_pkg;

  // Opcode patterns and masks
  localparam logic [7:0] JMP_MASK      = 8'h1F;
  localparam logic [7:0] JMP_CODE      = 8'h01;
  localparam logic [7:0] REG_MASK      = 8'hF8;
  localparam logic [7:0] AND_REG_CODE  = 8'h58;
  localparam logic [7:0] IND_MASK      = 8'hFE;
  localparam logic [7:0] AND_IND_CODE  = 8'h56;
  localparam logic [7:0] AND_DIR_CODE  = 8'h55;
  localparam logic [7:0] AND_IMM_CODE  = 8'h54;
  localparam logic [7:0] DIR_ACC_CODE  = 8'h52;
  localparam logic [7:0] DIR_IMM_CODE  = 8'h53;

  // Direct addresses from here up live in the special-function space
  localparam logic [7:0] SFR_BASE      = 8'h80;

  // Jump geometry: page target width and program counter advance
  localparam int         PAGE_W        = 11;
  localparam logic [1:0] JMP_PC_STEP   = 2'h2;

  // Instruction lengths in bytes and machine cycles
  localparam logic [1:0] LEN_1         = 2'h1;
  localparam logic [1:0] LEN_2         = 2'h2;
  localparam logic [1:0] LEN_3         = 2'h3;
  localparam logic [1:0] CYC_1         = 2'h1;
  localparam logic [1:0] CYC_2         = 2'h2;

  // Reset values
  localparam logic [7:0] BYTE_RST      = 8'h00;

  // Sequencer states, Gray coded along idle, pointer, source, writeback
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_RD_PTR = 2'h1,
    ST_RD_SRC = 2'h3,
    ST_WB     = 2'h2
  } state_t;

  // Instruction forms handled here
  typedef enum logic [2:0] {
    K_NONE    = 3'h0,
    K_JMP     = 3'h1,
    K_ACC_REG = 3'h2,
    K_ACC_DIR = 3'h3,
    K_ACC_IND = 3'h4,
    K_ACC_IMM = 3'h5,
    K_DIR_ACC = 3'h6,
    K_DIR_IMM = 3'h7
  } kind_t;

endpackage : page_jump_and_pkg

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import page_jump_and_pkg::*;
  // One instruction with what it must produce
  typedef struct {
    logic [7:0] op, b2, b3; logic [15:0] pc; logic [7:0] acc; logic [1:0] bank; int lat;
    logic [1:0] nb, nc; logic accw, memw, pcl, uns; logic [7:0] res, addr; logic [15:0] tgt; logic rmw, sfr;
  } row_t;
  logic        i_sys_clk, i_rst_n, i_instr_valid;
  logic [7:0]  i_opcode, i_byte2, i_byte3, i_acc, i_mem_rdata;
  logic [15:0] i_pc, o_pc_target;
  logic [1:0]  i_bank, o_bytes, o_cycles;
  logic        o_ready, o_done, o_unsupported, o_mem_rd, o_mem_wr, o_mem_sfr, o_mem_latch, o_acc_wr, o_pc_load;
  logic [7:0]  o_mem_addr, o_mem_wdata, o_acc_data;
  logic [7:0]  mem [256];
  int          err_total, checks_done;
  row_t        rows [10];
  row_t        rr;
  page_jump_and_logic_and_exec #(.PC_W(16)) page_jump_and_logic_and_exec_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid), .i_opcode(i_opcode),
    .i_byte2(i_byte2), .i_byte3(i_byte3), .i_pc(i_pc), .i_acc(i_acc), .i_bank(i_bank),
    .i_mem_rdata(i_mem_rdata), .o_ready(o_ready), .o_done(o_done), .o_bytes(o_bytes), .o_cycles(o_cycles),
    .o_unsupported(o_unsupported), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
    .o_mem_sfr(o_mem_sfr), .o_mem_latch(o_mem_latch), .o_mem_wdata(o_mem_wdata), .o_acc_wr(o_acc_wr),
    .o_acc_data(o_acc_data), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target));
  // Zero-latency memory; an idle port shows the inverted byte so stale data cannot pass
  assign i_mem_rdata = o_mem_rd ? mem[o_mem_addr] : ~mem[o_mem_addr];
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("Counts: %0d comparisons, %0d mismatches", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // Present one instruction, count pulses until it finishes; junk offers a jump while busy
  task automatic run(input row_t r, input bit junk);
    int n, pcn, accn, wrn;
    logic rmw_seen, sfr_seen;
    n = 0; pcn = 0; accn = 0; wrn = 0; rmw_seen = 1'b0; sfr_seen = 1'b0;
    while (o_ready !== 1'b1) begin
      @(posedge i_sys_clk);
      #1 n++;
      if (n > 20) begin check(16'h0000, 16'h0001, "ready timeout"); summarize(); end
    end
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b1; i_opcode <= r.op; i_byte2 <= r.b2; i_byte3 <= r.b3;
    i_pc <= r.pc; i_acc <= r.acc; i_bank <= r.bank;
    n = 0;
    // The first edge takes the instruction, so its one-cycle answers are sampled from there on
    do begin
      @(posedge i_sys_clk);
      if (n == 0) begin
        i_instr_valid <= junk;
        if (junk) i_opcode <= 8'h21;
      end else if (n == 1) begin
        i_instr_valid <= 1'b0;
      end
      #1 n++;
      if (o_pc_load !== 1'b0) pcn++;
      if (o_acc_wr !== 1'b0) accn++;
      if (o_mem_wr !== 1'b0) wrn++;
      if (o_mem_rd === 1'b1 && o_mem_latch === 1'b1) rmw_seen = 1'b1;
      if (o_mem_rd === 1'b1 && o_mem_sfr === 1'b1) sfr_seen = 1'b1;
      if (n > 10) begin check(16'h0000, 16'h0001, "done timeout"); summarize(); end
    end while (o_done !== 1'b1 && o_unsupported !== 1'b1);
    check(16'(n), 16'(r.lat), "latency");
    check(16'(o_unsupported), 16'(r.uns), "unsupported");
    check(16'(pcn), 16'(r.pcl), "pc loads");
    check(16'(accn), 16'(r.accw), "acc writes");
    check(16'(wrn), 16'(r.memw), "mem writes");
    if (!r.uns) check(16'(o_bytes), 16'(r.nb), "bytes");
    if (!r.uns) check(16'(o_cycles), 16'(r.nc), "cycles");
    if (r.pcl) check(o_pc_target, r.tgt, "target");
    if (r.accw) check(16'(o_acc_data), 16'(r.res), "acc result");
    if (r.memw) check(16'(o_mem_wdata), 16'(r.res), "write data");
    if (r.memw) check(16'(o_mem_addr), 16'(r.addr), "write address");
    check(16'(rmw_seen), 16'(r.rmw), "latch read");
    check(16'(sfr_seen), 16'(r.sfr), "sfr space");
    $display("Test op %h done", r.op);
  endtask : run
  initial begin
    err_total = 0; checks_done = 0;
    i_rst_n = 1'b0; i_instr_valid = 1'b0; i_opcode = 8'h00; i_byte2 = 8'h00; i_byte3 = 8'h00;
    i_pc = 16'h0000; i_acc = 8'h00; i_bank = 2'h0;
    for (int a = 0; a < 256; a++) mem[a] = 8'(a) ^ 8'hA5;
    mem[8'h15] = 8'h55; mem[8'h90] = 8'hF0; mem[8'h09] = 8'h40; mem[8'h40] = 8'h0F;
    mem[8'h00] = 8'h41; mem[8'h41] = 8'h3C; mem[8'h30] = 8'hCC;
    // Ordinary cases: jumps, every byte AND form, one foreign opcode
    rows = '{
      '{8'h21, 8'h23, 8'h00, 16'h0345, 8'h00, 2'h0, 1, 2'h2, 2'h2, 0, 0, 1, 0, 8'h00, 8'h00, 16'h0123, 0, 0},
      '{8'hA1, 8'h5A, 8'h00, 16'h7FFE, 8'h00, 2'h0, 1, 2'h2, 2'h2, 0, 0, 1, 0, 8'h00, 8'h00, 16'h855A, 0, 0},
      '{8'h5D, 8'h00, 8'h00, 16'h0100, 8'hC3, 2'h2, 3, 2'h1, 2'h1, 1, 0, 0, 0, 8'h41, 8'h00, 16'h0000, 0, 0},
      '{8'h55, 8'h90, 8'h00, 16'h0100, 8'h3C, 2'h0, 3, 2'h2, 2'h1, 1, 0, 0, 0, 8'h30, 8'h00, 16'h0000, 0, 1},
      '{8'h57, 8'h00, 8'h00, 16'h0100, 8'hFF, 2'h1, 4, 2'h1, 2'h1, 1, 0, 0, 0, 8'h0F, 8'h00, 16'h0000, 0, 0},
      '{8'h56, 8'h00, 8'h00, 16'h0100, 8'hF0, 2'h0, 4, 2'h1, 2'h1, 1, 0, 0, 0, 8'h30, 8'h00, 16'h0000, 0, 0},
      '{8'h54, 8'h73, 8'h00, 16'h0100, 8'hAA, 2'h0, 2, 2'h2, 2'h1, 1, 0, 0, 0, 8'h22, 8'h00, 16'h0000, 0, 0},
      '{8'h52, 8'h30, 8'h00, 16'h0100, 8'hA5, 2'h0, 3, 2'h2, 2'h1, 0, 1, 0, 0, 8'h84, 8'h30, 16'h0000, 1, 0},
      '{8'h53, 8'h90, 8'h73, 16'h0100, 8'h00, 2'h0, 3, 2'h3, 2'h2, 0, 1, 0, 0, 8'h70, 8'h90, 16'h0000, 1, 1},
      '{8'h00, 8'h00, 8'h00, 16'h0100, 8'h00, 2'h0, 1, 2'h0, 2'h0, 0, 0, 0, 1, 8'h00, 8'h00, 16'h0000, 0, 0}};
    // Reset held eight cycles; nothing may be ready or pulse meanwhile
    repeat (7) @(posedge i_sys_clk);
    #1 check(16'(o_ready), 16'h0000, "ready in reset");
    check(16'(o_done), 16'h0000, "done in reset");
    check(16'(o_pc_load), 16'h0000, "pc load in reset");
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    $display("Test reset done");
    foreach (rows[k]) run(rows[k], 1'b0);
    // Every working register of bank 3
    for (int r = 0; r < 8; r++) begin
      rr = rows[2];
      rr.op = 8'h58 | 8'(r); rr.bank = 2'h3; rr.acc = 8'hF3;
      rr.res = 8'hF3 & mem[8'h18 + 8'(r)];
      run(rr, 1'b0);
    end
    // A jump offered while busy must be ignored, not queued
    run(rows[6], 1'b1);
    run(rows[0], 1'b0);
    // Second reset in mid-run, then work resumes
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1 check(16'(o_ready), 16'h0000, "ready in second reset");
    check(16'(o_mem_rd), 16'h0000, "read in second reset");
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    run(rows[8], 1'b0);
    summarize();
  end
endmodule : tb_top
